// ==== design/soe_exec.sv ====
`timescale 1ns/1ns
// Notes on behaviour
// - Operand location from mode and register fields.
// - Modes: register, indirect, indexed, post-increment.
// - Call saves PC in link register.
// - Context call loads WP, then PC.
// - Old WP, PC, flags into new registers.
// - No interrupt sampling after context call.
// - Magnitude: flags from original, magnitude written.
// - Byte exchange in place, flags untouched.
// - Execute runs the word at operand address.
// - Extra words of executed op from PC.
// - No fetch flag on execute target read.
// - Count field zero means sixteen bits.
// - Serial start from base register bits.
// - Bits one by one; base register untouched.
// - Byte operand for counts one to eight.
// - Post-increment by one or two.
// - Serial out LSB first, flags from operand.
// - Serial in from LSB, rest zeroed.
// - Parity only for counts one to eight.
// - Single bit: base plus signed displacement.
// - Bit set drives one, clear drives zero.
// - Bit test copies input bit to equal.
module soe_exec import soe_pkg::*; #(
	parameter int DATA_W = 16
) (
	input wire logic ref_clk_i,
	input wire logic resetn_i,
	input wire logic start_i,
	input wire logic [15:0] instr_i,
	input wire soe_ctx_s ctx_i,
	input wire logic [15:0] mem_rdata_i,
	input wire logic mem_ack_i,
	input wire logic sio_din_i,
	output soe_ctx_s ctx_o,
	output logic done_o,
	output logic busy_o,
	output logic irq_sample_ok_o,
	output logic fetch_cycle_flag_o,
	output soe_mem_s mem_o,
	output soe_sio_s sio_o
);
	// The datapath is written for one word width only.
	if (DATA_W != WORD_W) begin : g_chk
		$error("soe_exec: DATA_W must equal the package word width.");
	end

	typedef enum logic [4:0] {
		S_IDLE, S_DEC, S_REG, S_IDX, S_INCW, S_OPER, S_RD, S_WR,
		S_LINK, S_BW_WP, S_BW_PC, S_BW_R13, S_BW_R14, S_BW_R15,
		S_XFETCH, S_IOB, S_BIT, S_BITW, S_SIO, S_DONE
	} soe_state_e;

	soe_state_e state, next_state; // Sequencer state.
	logic [15:0] ir, next_ir; // Instruction being executed.
	soe_ctx_s ctx, next_ctx; // Working copy of PC, WP and flags.
	logic [15:0] addr, next_addr; // Resolved operand address.
	logic [15:0] regv, next_regv; // Register value or new PC.
	logic [15:0] nwp, next_nwp; // Context being switched to.
	logic [15:0] opnd, next_opnd; // Operand or result value.
	logic [4:0] cnt, next_cnt; // Bits to move.
	logic [4:0] bitn, next_bitn; // Bits issued so far.
	logic done, next_done; // End of instruction pulse.
	logic irq_ok, next_irq_ok; // Interrupt may be sampled.
	soe_mem_s mem, next_mem; // Registered memory request.
	soe_sio_s sio, next_sio; // Registered serial access.

	// Decoded views of the instruction register.
	soe_one_s f1;
	soe_multi_s fm;
	soe_bit_s fb;
	logic is_multi, is_bit, byte_mode;
	assign f1 = ir;
	assign fm = ir;
	assign fb = ir;
	assign is_multi = (fm.op == OP_SOUT) || (fm.op == OP_SIN);
	assign is_bit = (fb.op == OP_BSET) || (fb.op == OP_BCLR) ||
		(fb.op == OP_BTEST);
	// Byte operand only for short multi-bit counts.
	assign byte_mode = is_multi && (cnt <= BYTE_MAX_CNT);

	// Byte address of a workspace register for the given workspace pointer.
	function automatic logic [15:0] reg_addr(input logic [15:0] wp,
		input logic [3:0] r);
		reg_addr = wp + {11'h000, r, 1'b0};
	endfunction

	// Builds one memory request.
	function automatic soe_mem_s cmd(input logic we,
		input logic [15:0] a, input logic [15:0] d, input logic [1:0] be);
		cmd = '{req: 1'b1, we: we, be: be, addr: a, wdata: d};
	endfunction

	// Operand write, narrowed to one byte lane in byte mode.
	function automatic soe_mem_s op_write(input logic [15:0] a,
		input logic [15:0] v, input logic bm);
		if (bm) begin
			op_write = cmd(1'b1, a, {v[7:0], v[7:0]},
				a[0] ? BE_LO : BE_HI);
		end else begin
			op_write = cmd(1'b1, a, v, BE_WORD);
		end
	endfunction

	// Flags 0 to 2 from comparing a value with zero.
	function automatic logic [15:0] cmp0(input logic [15:0] st,
		input logic [15:0] v);
		cmp0 = st;
		cmp0[ST_LGT] = (v != 16'h0000);
		cmp0[ST_AGT] = !v[15] && (v != 16'h0000);
		cmp0[ST_EQ] = (v == 16'h0000);
	endfunction

	// Flags for a serial operand; parity only in byte mode.
	function automatic logic [15:0] sio_flags(input logic [15:0] st,
		input logic [15:0] v, input logic bm);
		if (bm) begin
			sio_flags = cmp0(st, {v[7:0], 8'h00});
			sio_flags[ST_PAR] = ^v[7:0];
		end else begin
			sio_flags = cmp0(st, v);
		end
	endfunction

	// Next-state logic for the whole sequencer.
	always_comb begin
		logic [15:0] v;
		logic [16:0] sum;
		logic [15:0] k;
		v = 16'h0000;
		sum = 17'h00000;
		k = 16'h0000;
		next_state = state;
		next_ir = ir;
		next_ctx = ctx;
		next_addr = addr;
		next_regv = regv;
		next_nwp = nwp;
		next_opnd = opnd;
		next_cnt = cnt;
		next_bitn = bitn;
		next_done = 1'b0;
		next_irq_ok = irq_ok;
		// A request ends on its acknowledge unless a new one follows.
		next_mem = mem;
		next_mem.req = mem.req && !mem_ack_i;
		// Serial strobes last one cycle; the address holds.
		next_sio = sio;
		next_sio.we = 1'b0;
		next_sio.rd = 1'b0;
		case (state)
			S_IDLE: begin
				if (start_i) begin
					next_ir = instr_i;
					next_ctx = ctx_i;
					next_irq_ok = 1'b1;
					next_state = S_DEC;
				end
			end
			S_DEC: begin
				// Count field zero stands for a full word.
				next_cnt = (fm.cnt == 4'h0) ? FULL_CNT
					: {1'b0, fm.cnt};
				if (is_bit) begin
					next_mem = cmd(1'b0, reg_addr(ctx.wp, IO_BASE_REG),
						16'h0000, BE_WORD);
					next_state = S_IOB;
				end else if (!is_multi && (f1.op < OP_CTX_CALL ||
					f1.op > OP_ABS)) begin
					// Opcodes outside this block finish with no effect.
					next_state = S_DONE;
				end else if (f1.ts == TS_REG) begin
					next_addr = reg_addr(ctx.wp, f1.sreg);
					next_state = S_OPER;
				end else if (f1.ts == TS_IDX && f1.sreg == 4'h0) begin
					// Symbolic: the address word follows at PC.
					next_mem = cmd(1'b0, ctx.pc, 16'h0000, BE_WORD);
					next_state = S_IDX;
				end else begin
					next_mem = cmd(1'b0, reg_addr(ctx.wp, f1.sreg),
						16'h0000, BE_WORD);
					next_state = S_REG;
				end
			end
			S_REG: begin
				if (mem_ack_i) begin
					next_regv = mem_rdata_i;
					next_addr = mem_rdata_i;
					if (f1.ts == TS_IND) begin
						next_state = S_OPER;
					end else if (f1.ts == TS_INC) begin
						// Pointer steps by the operand size.
						k = byte_mode ? STEP_ONE : STEP_TWO;
						next_mem = cmd(1'b1, reg_addr(ctx.wp, f1.sreg),
							mem_rdata_i + k, BE_WORD);
						next_state = S_INCW;
					end else begin
						next_mem = cmd(1'b0, ctx.pc, 16'h0000, BE_WORD);
						next_state = S_IDX;
					end
				end
			end
			S_IDX: begin
				// Index word comes from PC, which then moves on.
				if (mem_ack_i) begin
					next_addr = mem_rdata_i +
						((f1.sreg == 4'h0) ? 16'h0000 : regv);
					next_ctx.pc = ctx.pc + STEP_TWO;
					next_state = S_OPER;
				end
			end
			S_INCW: begin
				if (mem_ack_i) begin
					next_state = S_OPER;
				end
			end
			S_OPER: begin
				if (is_multi) begin
					next_opnd = 16'h0000;
					if (fm.op == OP_SIN) begin
						next_mem = cmd(1'b0, reg_addr(ctx.wp, IO_BASE_REG),
							16'h0000, BE_WORD);
						next_state = S_IOB;
					end else begin
						next_mem = cmd(1'b0, addr, 16'h0000, BE_WORD);
						next_state = S_RD;
					end
				end else begin
					case (f1.op)
						OP_BRANCH: begin
							next_ctx.pc = addr;
							next_state = S_DONE;
						end
						OP_CALL_LINK: begin
							next_mem = cmd(1'b1, reg_addr(ctx.wp, LINK_REG),
								ctx.pc, BE_WORD);
							next_state = S_LINK;
						end
						OP_CTX_CALL: begin
							next_mem = cmd(1'b0, addr, 16'h0000, BE_WORD);
							next_state = S_BW_WP;
						end
						OP_EXEC: begin
							next_mem = cmd(1'b0, addr, 16'h0000, BE_WORD);
							next_state = S_XFETCH;
						end
						OP_ZERO, OP_ONES: begin
							// Plain fills; the old value is not needed.
							next_opnd = (f1.op == OP_ONES) ? ONES_WORD
								: 16'h0000;
							next_mem = op_write(addr, next_opnd, 1'b0);
							next_state = S_WR;
						end
						default: begin
							next_mem = cmd(1'b0, addr, 16'h0000, BE_WORD);
							next_state = S_RD;
						end
					endcase
				end
			end
			S_RD: begin
				if (mem_ack_i) begin
					v = mem_rdata_i;
					if (byte_mode) begin
						v = {8'h00, addr[0] ? v[7:0] : v[15:8]};
					end
					if (is_multi) begin
						// Serial out: flags from the operand itself.
						next_opnd = v;
						next_ctx.st = sio_flags(ctx.st, v,
							byte_mode);
						next_mem = cmd(1'b0, reg_addr(ctx.wp, IO_BASE_REG),
							16'h0000, BE_WORD);
						next_state = S_IOB;
					end else begin
						case (f1.op)
							OP_INV: begin
								next_opnd = ~v;
								next_ctx.st = cmp0(ctx.st, ~v);
							end
							OP_SWAP: begin
								// Flags deliberately left alone.
								next_opnd = {v[7:0], v[15:8]};
							end
							OP_ABS: begin
								// Flags come from the value before the change.
								sum = {1'b0, ~v} + 17'h00001;
								next_opnd = v[15] ? sum[15:0] : v;
								next_ctx.st = cmp0(ctx.st, v);
								next_ctx.st[ST_CY] = v[15] && sum[16];
								next_ctx.st[ST_OV] = (v == MIN_NEG);
							end
							OP_NEG: begin
								sum = {1'b0, ~v} + 17'h00001;
								next_opnd = sum[15:0];
								next_ctx.st = cmp0(ctx.st, sum[15:0]);
								next_ctx.st[ST_CY] = sum[16];
								next_ctx.st[ST_OV] = (v == MIN_NEG);
							end
							default: begin
								// Add or subtract one or two.
								case (f1.op)
									OP_INC: k = STEP_ONE;
									OP_ADD_TWO_OP: k = STEP_TWO;
									OP_DEC: k = ~STEP_ONE + STEP_ONE;
									default: k = ~STEP_TWO + STEP_ONE;
								endcase
								sum = {1'b0, v} + {1'b0, k};
								next_opnd = sum[15:0];
								next_ctx.st = cmp0(ctx.st, sum[15:0]);
								next_ctx.st[ST_CY] = sum[16];
								next_ctx.st[ST_OV] = (v[15] == k[15]) &&
									(sum[15] != v[15]);
							end
						endcase
						next_mem = op_write(addr, next_opnd, 1'b0);
						next_state = S_WR;
					end
				end
			end
			S_WR: begin
				if (mem_ack_i) begin
					next_state = S_DONE;
				end
			end
			S_LINK: begin
				if (mem_ack_i) begin
					next_ctx.pc = addr;
					next_state = S_DONE;
				end
			end
			S_BW_WP: begin
				if (mem_ack_i) begin
					next_nwp = mem_rdata_i;
					next_mem = cmd(1'b0, addr + CTX_PC_OFS, 16'h0000,
						BE_WORD);
					next_state = S_BW_PC;
				end
			end
			S_BW_PC: begin
				if (mem_ack_i) begin
					next_regv = mem_rdata_i;
					next_mem = cmd(1'b1, reg_addr(nwp, CTX_WP_REG), ctx.wp,
						BE_WORD);
					next_state = S_BW_R13;
				end
			end
			S_BW_R13: begin
				if (mem_ack_i) begin
					next_mem = cmd(1'b1, reg_addr(nwp, CTX_PC_REG), ctx.pc,
						BE_WORD);
					next_state = S_BW_R14;
				end
			end
			S_BW_R14: begin
				if (mem_ack_i) begin
					next_mem = cmd(1'b1, reg_addr(nwp, CTX_ST_REG), ctx.st,
						BE_WORD);
					next_state = S_BW_R15;
				end
			end
			S_BW_R15: begin
				if (mem_ack_i) begin
					next_ctx.wp = nwp;
					next_ctx.pc = regv;
					// The next fetch must not be pre-empted.
					next_irq_ok = 1'b0;
					next_state = S_DONE;
				end
			end
			S_XFETCH: begin
				// Target word becomes the instruction; PC stays put.
				if (mem_ack_i) begin
					next_ir = mem_rdata_i;
					next_state = S_DEC;
				end
			end
			S_IOB: begin
				if (mem_ack_i) begin
					if (is_bit) begin
						next_sio.addr = mem_rdata_i[IOB_MSB:IOB_LSB] +
							{{4{fb.disp[7]}}, fb.disp};
						next_state = S_BIT;
					end else begin
						next_sio.addr =
							mem_rdata_i[IOB_MSB:IOB_LSB];
						next_bitn = 5'h00;
						next_state = S_SIO;
					end
				end
			end
			S_BIT: begin
				if (fb.op == OP_BTEST) begin
					next_sio.rd = 1'b1;
				end else begin
					next_sio.we = 1'b1;
					next_sio.dout = (fb.op == OP_BSET);
				end
				next_state = S_BITW;
			end
			S_BITW: begin
				// Input sampled while the read strobe is out.
				if (sio.rd) begin
					next_ctx.st[ST_EQ] = sio_din_i;
				end
				next_state = S_DONE;
			end
			S_SIO: begin
				// One bit per cycle; the copy of the base advances.
				v = opnd;
				if (sio.rd) begin
					v[4'(bitn - 5'h01)] = sio_din_i;
				end
				next_opnd = v;
				if (bitn != cnt) begin
					next_sio.addr = sio.addr + ((bitn != 5'h00)
						? 12'h001 : 12'h000);
					next_sio.we = (fm.op == OP_SOUT);
					next_sio.rd = (fm.op == OP_SIN);
					next_sio.dout = opnd[4'(bitn)];
					next_bitn = bitn + 5'h01;
				end else if (fm.op == OP_SIN) begin
					// Positions never filled stay zero from S_OPER.
					next_ctx.st = sio_flags(ctx.st, v,
						byte_mode);
					next_mem = op_write(addr, v, byte_mode);
					next_state = S_WR;
				end else begin
					next_state = S_DONE;
				end
			end
			S_DONE: begin
				next_done = 1'b1;
				next_state = S_IDLE;
			end
			default: begin
				next_state = S_IDLE;
			end
		endcase
	end

	// State registers; asynchronous reset to an idle machine.
	always_ff @(posedge ref_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			state <= S_IDLE;
			ir <= 16'h0000;
			ctx <= '0;
			addr <= 16'h0000;
			regv <= 16'h0000;
			nwp <= 16'h0000;
			opnd <= 16'h0000;
			cnt <= 5'h00;
			bitn <= 5'h00;
			done <= 1'b0;
			irq_ok <= 1'b1;
			mem <= '0;
			sio <= '0;
		end else begin
			state <= next_state;
			ir <= next_ir;
			ctx <= next_ctx;
			addr <= next_addr;
			regv <= next_regv;
			nwp <= next_nwp;
			opnd <= next_opnd;
			cnt <= next_cnt;
			bitn <= next_bitn;
			done <= next_done;
			irq_ok <= next_irq_ok;
			mem <= next_mem;
			sio <= next_sio;
		end
	end

	// The fetch flag stays low, even when this block reads the execute target word into the instruction register.
	assign fetch_cycle_flag_o = 1'b0;
	assign ctx_o = ctx;
	assign done_o = done;
	assign busy_o = (state != S_IDLE);
	assign irq_sample_ok_o = irq_ok;
	assign mem_o = mem;
	assign sio_o = sio;
endmodule

// ==== design/soe_pkg.sv ====
package soe_pkg;
	// Machine word width in bits.
	localparam int WORD_W = 16;
	// Width of the serial I/O bit address.
	localparam int SIO_AW = 12;

	// Ten-bit opcodes of the single-operand group.
	localparam logic [9:0] OP_BRANCH = 10'h011;
	localparam logic [9:0] OP_CALL_LINK = 10'h01A;
	localparam logic [9:0] OP_CTX_CALL = 10'h010;
	localparam logic [9:0] OP_ZERO = 10'h013;
	localparam logic [9:0] OP_ONES = 10'h01C;
	localparam logic [9:0] OP_INV = 10'h015;
	localparam logic [9:0] OP_NEG = 10'h014;
	localparam logic [9:0] OP_ABS = 10'h01D;
	localparam logic [9:0] OP_SWAP = 10'h01B;
	localparam logic [9:0] OP_INC = 10'h016;
	localparam logic [9:0] OP_ADD_TWO_OP = 10'h017;
	localparam logic [9:0] OP_DEC = 10'h018;
	localparam logic [9:0] OP_SUB_TWO_OP = 10'h019;
	localparam logic [9:0] OP_EXEC = 10'h012;
	// Six-bit opcodes of the multi-bit serial group.
	localparam logic [5:0] OP_SOUT = 6'h0C;
	localparam logic [5:0] OP_SIN = 6'h0D;
	// Eight-bit opcodes of the single-bit serial group.
	localparam logic [7:0] OP_BSET = 8'h1D;
	localparam logic [7:0] OP_BCLR = 8'h1E;
	localparam logic [7:0] OP_BTEST = 8'h1F;

	// Source addressing modes.
	localparam logic [1:0] TS_REG = 2'h0;
	localparam logic [1:0] TS_IND = 2'h1;
	localparam logic [1:0] TS_IDX = 2'h2;
	localparam logic [1:0] TS_INC = 2'h3;

	// Workspace register numbers with a fixed role.
	localparam logic [3:0] LINK_REG = 4'hB;
	localparam logic [3:0] IO_BASE_REG = 4'hC;
	localparam logic [3:0] CTX_WP_REG = 4'hD;
	localparam logic [3:0] CTX_PC_REG = 4'hE;
	localparam logic [3:0] CTX_ST_REG = 4'hF;
	// Bits of the base register that hold the serial base address.
	localparam int IOB_MSB = 12;
	localparam int IOB_LSB = 1;

	// Flag word bit positions; flag 0 is the most significant bit.
	localparam int ST_LGT = 15;
	localparam int ST_AGT = 14;
	localparam int ST_EQ = 13;
	localparam int ST_CY = 12;
	localparam int ST_OV = 11;
	localparam int ST_PAR = 10;

	// Constants used by the arithmetic, the serial counter and the memory requests.
	localparam logic [15:0] ONES_WORD = 16'hFFFF;
	localparam logic [15:0] MIN_NEG = 16'h8000;
	localparam logic [15:0] STEP_ONE = 16'h0001;
	localparam logic [15:0] STEP_TWO = 16'h0002;
	localparam logic [15:0] CTX_PC_OFS = 16'h0002;
	localparam logic [4:0] BYTE_MAX_CNT = 5'h08;
	localparam logic [4:0] FULL_CNT = 5'h10;
	localparam logic [1:0] BE_WORD = 2'h3;
	localparam logic [1:0] BE_HI = 2'h2;
	localparam logic [1:0] BE_LO = 2'h1;

	// Instruction layouts, most significant field first.
	typedef struct packed {
		logic [9:0] op;
		logic [1:0] ts;
		logic [3:0] sreg;
	} soe_one_s;
	typedef struct packed {
		logic [5:0] op;
		logic [3:0] cnt;
		logic [1:0] ts;
		logic [3:0] sreg;
	} soe_multi_s;
	typedef struct packed {
		logic [7:0] op;
		logic [7:0] disp;
	} soe_bit_s;

	// Processor context handed in at start and back at done.
	typedef struct packed {
		logic [15:0] pc;
		logic [15:0] wp;
		logic [15:0] st;
	} soe_ctx_s;
	// Memory request; be[1] selects the even (upper) byte.
	typedef struct packed {
		logic req;
		logic we;
		logic [1:0] be;
		logic [15:0] addr;
		logic [15:0] wdata;
	} soe_mem_s;
	// Serial bit-space access.
	typedef struct packed {
		logic we;
		logic rd;
		logic dout;
		logic [SIO_AW-1:0] addr;
	} soe_sio_s;
endpackage

// ==== dv/soe_exec_checker.sv ====
`timescale 1ns/1ns
// Port-level checks on flags, serial pacing and request holding.
module soe_exec_checker import soe_pkg::*; (
	input wire logic ref_clk_i,
	input wire logic resetn_i,
	input wire logic start_i,
	input wire logic [15:0] instr_i,
	input wire soe_ctx_s ctx_i,
	input wire logic mem_ack_i,
	input wire soe_ctx_s ctx_o,
	input wire logic done_o,
	input wire logic busy_o,
	input wire logic irq_sample_ok_o,
	input wire logic fetch_cycle_flag_o,
	input wire soe_mem_s mem_o,
	input wire soe_sio_s sio_o
);
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (!resetn_i);
	logic [15:0] ins_cap; // Instruction of the last start.
	logic [15:0] st_cap; // Flags of that start.
	logic [4:0] pulses; // Serial pulses since that start.
	logic [15:0] next_ins_cap, next_st_cap;
	logic [4:0] next_pulses, want_pulses;
	// Capture on an accepted start; one while busy is ignored.
	always_comb begin
		next_ins_cap = ins_cap;
		next_st_cap = st_cap;
		next_pulses = pulses;
		if (start_i && !busy_o) begin
			next_ins_cap = instr_i;
			next_st_cap = ctx_i.st;
			next_pulses = 5'h00;
		end else if (sio_o.we || sio_o.rd) begin
			next_pulses = pulses + 5'h01;
		end
	end
	// A zero count field means sixteen bits.
	assign want_pulses = (ins_cap[9:6] == 4'h0) ? FULL_CNT : {1'b0, ins_cap[9:6]};
	// Registers only.
	always_ff @(posedge ref_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			ins_cap <= 16'h0000;
			st_cap <= 16'h0000;
			pulses <= 5'h00;
		end else begin
			ins_cap <= next_ins_cap;
			st_cap <= next_st_cap;
			pulses <= next_pulses;
		end
	end
	chk_fetch_low: assert property (!fetch_cycle_flag_o)
		else $error("fetch flag raised");
	chk_swap_flags: assert property (done_o && ins_cap[15:6] == OP_SWAP |-> ctx_o.st == st_cap)
		else $error("byte exchange changed flags");
	chk_bit_flags: assert property (done_o && (ins_cap[15:8] == OP_BSET || ins_cap[15:8] == OP_BCLR) |-> ctx_o.st == st_cap)
		else $error("bit set/clear changed flags");
	chk_bit_level: assert property (sio_o.we && (ins_cap[15:8] == OP_BSET || ins_cap[15:8] == OP_BCLR) |-> sio_o.dout == (ins_cap[15:8] == OP_BSET))
		else $error("wrong bit level driven");
	chk_ctx_noirq: assert property (done_o && ins_cap[15:6] == OP_CTX_CALL |-> !irq_sample_ok_o)
		else $error("irq allowed after context call");
	chk_irq_back: assert property (done_o && ins_cap[15:6] == OP_BRANCH |-> irq_sample_ok_o)
		else $error("irq blocked after branch");
	chk_sio_step: assert property ((sio_o.we && $past(sio_o.we)) || (sio_o.rd && $past(sio_o.rd)) |-> sio_o.addr == $past(sio_o.addr) + 12'h001)
		else $error("serial address not stepped by one");
	chk_bit_count: assert property (done_o && ins_cap[15:11] == 5'h06 |-> pulses == want_pulses)
		else $error("wrong serial bit count");
	chk_word_store: assert property (mem_o.req && mem_o.we && ins_cap[15:10] == OP_SIN && want_pulses > BYTE_MAX_CNT |-> mem_o.be == BE_WORD)
		else $error("word transfer stored as byte");
	chk_mem_hold: assert property (mem_o.req && !mem_ack_i |=> $stable(mem_o))
		else $error("request changed before ack");
endmodule

bind soe_exec soe_exec_checker u_chk (.ref_clk_i, .resetn_i, .start_i,
	.instr_i, .ctx_i, .mem_ack_i, .ctx_o, .done_o, .busy_o,
	.irq_sample_ok_o, .fetch_cycle_flag_o, .mem_o, .sio_o);

// ==== dv/soe_far_model.sv ====
`timescale 1ns/1ns
// Memory and serial bit space beyond the executor.
module soe_far_model import soe_pkg::*; (
	input wire logic ref_clk_i,
	input wire logic resetn_i,
	input wire soe_mem_s mem_i,
	input wire soe_sio_s sio_i,
	output logic [15:0] mem_rdata_o,
	output logic mem_ack_o,
	output logic sio_din_o
);
	logic [15:0] mem [0:255]; // Words, indexed by address bits 8..1.
	logic out_bits [0:4095]; // Output latches of the bit space.
	logic in_bits [0:4095]; // Input levels of the bit space.
	int lat; // Wait cycles before each acknowledge.
	int waited; // Wait cycles spent on the open request.
	// Input bits are levels; the addressed one is always shown.
	assign sio_din_o = in_bits[sio_i.addr];
	// Plain always, so the bench may preload the arrays.
	always @(posedge ref_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			mem_ack_o <= 1'b0;
			mem_rdata_o <= 16'h0000;
			waited <= 0;
		end else begin
			mem_ack_o <= 1'b0;
			// Data toggles outside the answer cycle, so stale data fails.
			mem_rdata_o <= ~mem_rdata_o;
			if (mem_i.req && !mem_ack_o) begin
				if (waited >= lat) begin
					mem_ack_o <= 1'b1;
					mem_rdata_o <= mem[mem_i.addr[8:1]];
					waited <= 0;
				end else begin
					waited <= waited + 1;
				end
			end
			// A write lands at the edge that sees its acknowledge.
			if (mem_i.req && mem_ack_o && mem_i.we && mem_i.be[1]) begin
				mem[mem_i.addr[8:1]][15:8] <= mem_i.wdata[15:8];
			end
			if (mem_i.req && mem_ack_o && mem_i.we && mem_i.be[0]) begin
				mem[mem_i.addr[8:1]][7:0] <= mem_i.wdata[7:0];
			end
			if (sio_i.we) begin
				out_bits[sio_i.addr] <= sio_i.dout;
			end
		end
	end
endmodule

// ==== dv/tb_single_operand_and_serial_io_exec.sv ====
`timescale 1ns/1ns
// Drives start/done and checks memory, bits and context.
module tb_single_operand_and_serial_io_exec import soe_pkg::*;;
	localparam logic [15:0] WPA = 16'h0100; // Caller workspace.
	localparam logic [15:0] PCA = 16'h0040; // Address after the instruction.
	localparam int BASE = 32; // Serial base held in the base register.
	logic ref_clk_i, resetn_i, start_i, mem_ack_i, sio_din_i;
	logic done_o, busy_o, irq_sample_ok_o, fetch_cycle_flag_o, res_irq;
	logic [15:0] instr_i, mem_rdata_i;
	soe_ctx_s ctx_i, ctx_o, res;
	soe_mem_s mem_o;
	soe_sio_s sio_o;
	int errors, samples_checked, cycles, i, a;
	// Unary table: opcode, operand, result, flags from FC00.
	logic [9:0] t_op [12] = '{OP_ZERO, OP_ONES, OP_INV, OP_NEG, OP_NEG, OP_ABS, OP_ABS, OP_SWAP, OP_INC, OP_ADD_TWO_OP, OP_DEC, OP_SUB_TWO_OP};
	logic [15:0] t_in [12] = '{16'h1234, 16'h1234, 16'h00FF, 16'h0001, 16'h0000, 16'hFFFE, 16'h8000, 16'h1234, 16'hFFFF, 16'h7FFF, 16'h0001, 16'h0001};
	logic [15:0] t_out [12] = '{16'h0000, 16'hFFFF, 16'hFF00, 16'hFFFF, 16'h0000, 16'h0002, 16'h8000, 16'h3412, 16'h0000, 16'h8001, 16'h0000, 16'hFFFF};
	logic [15:0] t_st [12] = '{16'hFC00, 16'hFC00, 16'h9C00, 16'h8400, 16'h3400, 16'h8400, 16'h8C00, 16'hFC00, 16'h3400, 16'h8C00, 16'h3400, 16'h8400};
	// Bit table: opcode, displacement, flags in, flags out.
	logic [7:0] b_op [4] = '{OP_BSET, OP_BCLR, OP_BTEST, OP_BTEST};
	logic [7:0] b_dsp [4] = '{8'hFE, 8'h05, 8'h01, 8'h03};
	logic [15:0] b_sti [4] = '{16'hFC00, 16'h0000, 16'h0000, 16'hFC00};
	logic [15:0] b_sto [4] = '{16'hFC00, 16'h0000, 16'h2000, 16'hDC00};
	soe_exec dut (.ref_clk_i, .resetn_i, .start_i, .instr_i, .ctx_i,
		.mem_rdata_i, .mem_ack_i, .sio_din_i, .ctx_o, .done_o, .busy_o,
		.irq_sample_ok_o, .fetch_cycle_flag_o, .mem_o, .sio_o);
	soe_far_model mdl (.ref_clk_i, .resetn_i, .mem_i(mem_o), .sio_i(sio_o),
		.mem_rdata_o(mem_rdata_i), .mem_ack_o(mem_ack_i), .sio_din_o(sio_din_i));
	always #2 ref_clk_i = ~ref_clk_i;
	// The run needs about 450 cycles; a hang stops here.
	always @(posedge ref_clk_i) begin
		cycles++;
		if (cycles == 8000) begin
			errors++;
			$display("[ERR] %0t timeout", $time);
			final_report();
		end
	end
	task automatic final_report();
		$display("errors=%0d samples_checked=%0d", errors, samples_checked);
		if (errors == 0 && samples_checked > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	task automatic chk(input logic [15:0] got, exp);
		samples_checked++;
		if (got !== exp) begin
			errors++;
			$display("[ERR] %0t got %h want %h", $time, got, exp);
		end
	endtask
	task automatic wm(input logic [15:0] ad, d);
		mdl.mem[ad[8:1]] = d;
	endtask
	function automatic logic [15:0] rm(input logic [15:0] ad);
		return mdl.mem[ad[8:1]];
	endfunction
	// Start pulse, then a bounded wait for done; keeps the context.
	task automatic run(input logic [15:0] ins, st);
		int n;
		@(negedge ref_clk_i);
		start_i = 1'b1;
		instr_i = ins;
		ctx_i = {PCA, WPA, st};
		@(negedge ref_clk_i);
		start_i = 1'b0;
		n = 0;
		while (done_o !== 1'b1 && n < 300) begin
			@(negedge ref_clk_i);
			n++;
		end
		res = ctx_o;
		res_irq = irq_sample_ok_o;
		chk(16'(done_o), 16'h0001);
	endtask
	// Serial out from ad; bit k must land at BASE+k.
	task automatic sout(input logic [3:0] c, input logic [1:0] ts, input logic [3:0] r, input logic [15:0] ad, w, v, st);
		int n;
		n = (c == 4'h0) ? 16 : int'(c);
		wm(ad, w);
		for (int k = 0; k < 16; k++) mdl.out_bits[BASE + k] = ~v[k];
		run({OP_SOUT, c, ts, r}, 16'hFC00);
		for (int k = 0; k < n; k++) chk(16'(mdl.out_bits[BASE + k]), 16'(v[k]));
		chk(res.st, st);
		chk(rm(WPA + 16'h0018), 16'h0040);
	endtask
	initial begin
		ref_clk_i = 1'b0;
		resetn_i = 1'b0;
		start_i = 1'b0;
		instr_i = 16'h0000;
		ctx_i = '0;
		for (i = 0; i < 4096; i++) mdl.in_bits[i] = (i % 3 == 0);
		for (i = 0; i < 256; i++) mdl.mem[i] = 16'h0000;
		repeat (5) @(negedge ref_clk_i);
		resetn_i = 1'b1;
		wm(WPA + 16'h0018, 16'h0040);
		// Unary ops on register 1, memory waits of 0 to 2.
		for (i = 0; i < 12; i++) begin
			mdl.lat = i % 3;
			wm(WPA + 16'h0002, t_in[i]);
			run({t_op[i], TS_REG, 4'h1}, 16'hFC00);
			chk(rm(WPA + 16'h0002), t_out[i]);
			chk(res.st, t_st[i]);
		end
		// Indirect, post-increment, indexed and symbolic operands.
		wm(WPA + 16'h0004, 16'h0180);
		wm(16'h0180, 16'h0010);
		run({OP_INC, TS_IND, 4'h2}, 16'h0000);
		chk(rm(16'h0180), 16'h0011);
		run({OP_INC, TS_INC, 4'h2}, 16'h0000);
		chk(rm(16'h0180), 16'h0012);
		chk(rm(WPA + 16'h0004), 16'h0182);
		wm(PCA, 16'h0180);
		wm(WPA + 16'h0006, 16'h0004);
		run({OP_INC, TS_IDX, 4'h3}, 16'h0000);
		chk(rm(16'h0184), 16'h0001);
		chk(res.pc, PCA + 16'h0002);
		wm(PCA, 16'h0184);
		run({OP_INC, TS_IDX, 4'h0}, 16'h0000);
		chk(rm(16'h0184), 16'h0002);
		// Branch, call with link and context-switch call.
		wm(WPA + 16'h0004, 16'h0160);
		run({OP_BRANCH, TS_REG, 4'h1}, 16'h0000);
		chk(res.pc, WPA + 16'h0002);
		run({OP_CALL_LINK, TS_IND, 4'h2}, 16'h0000);
		chk(res.pc, 16'h0160);
		chk(rm(WPA + 16'h0016), PCA);
		wm(WPA + 16'h0004, 16'h01C0);
		wm(16'h01C0, 16'h0120);
		wm(16'h01C2, 16'h0160);
		run({OP_CTX_CALL, TS_IND, 4'h2}, 16'h2300);
		chk(res.wp, 16'h0120);
		chk(res.pc, 16'h0160);
		chk(rm(16'h013A), WPA);
		chk(rm(16'h013C), PCA);
		chk(rm(16'h013E), 16'h2300);
		chk(16'(res_irq), 16'h0000);
		// Execute a symbolic increment; its word follows at PC.
		wm(16'h01C4, {OP_INC, TS_IDX, 4'h0});
		wm(16'h0184, 16'h7FFF);
		wm(WPA + 16'h0004, 16'h01C4);
		run({OP_EXEC, TS_IND, 4'h2}, 16'h0000);
		chk(rm(16'h0184), 16'h8000);
		chk(res.pc, PCA + 16'h0002);
		chk(res.st, 16'h8800);
		chk(16'(res_irq), 16'h0001);
		// Serial out: odd byte, post-increment, then a full word.
		wm(WPA + 16'h0004, 16'h0181);
		sout(4'h3, TS_INC, 4'h2, 16'h0180, 16'h12A5, 16'h00A5, 16'h9800);
		chk(rm(WPA + 16'h0004), 16'h0182);
		wm(WPA + 16'h0008, 16'h0184);
		sout(4'h0, TS_IND, 4'h4, 16'h0184, 16'h8001, 16'h8001, 16'h9C00);
		// Input bits are 1 at addresses divisible by three.
		wm(WPA + 16'h000A, 16'h0187);
		wm(16'h0186, 16'h5500);
		run({OP_SIN, 4'h4, TS_IND, 4'h5}, 16'h0000);
		chk(rm(16'h0186), 16'h5502);
		chk(res.st, 16'hC400);
		wm(WPA + 16'h000C, 16'hFFFF);
		run({OP_SIN, 4'h9, TS_REG, 4'h6}, 16'h0000);
		chk(rm(WPA + 16'h000C), 16'h0092);
		chk(res.st, 16'hC000);
		// Single bits at base plus a signed displacement.
		for (i = 0; i < 4; i++) begin
			a = BASE + int'($signed(b_dsp[i]));
			mdl.out_bits[a] = i[0];
			run({b_op[i], b_dsp[i]}, b_sti[i]);
			chk(res.st, b_sto[i]);
			if (i < 2) chk(16'(mdl.out_bits[a]), 16'(!i[0]));
		end
		final_report();
	end
endmodule
